// File: bfs_pkg.sv
package bfs_pkg;
   // port widths
   localparam int DATA_W = 36;
   localparam int ADDR_W = 18;
   localparam int LANE_W = 9;
   localparam int LANES = 4;
   localparam int BEATS = 4;
   localparam int LINE_W = 144;
   localparam int LINE_LANES = 16;
   localparam int ZQ_W = 6;
   // impedance code after reset: middle of the range
   localparam logic [5:0] ZQ_MID = 6'h20;
   // settle and relock counts, in cycles
   localparam logic [10:0] CAL_CYCLES = 11'h400;
   localparam logic [10:0] LOCK_CYCLES = 11'h400;
   localparam logic [10:0] ZQ_PERIOD = 11'h100;
   localparam logic [10:0] CNT_ZERO = 11'h000;
   localparam logic [3:0] STOP_DETECT = 4'h8;
   localparam logic [2:0] SHIFT_ZERO = 3'h0;
endpackage

// File: bfs_line_mem.sv
`timescale 1ns/10ps
module bfs_line_mem (
   input wire logic clk, // link clock
   input wire logic wr_en, // commit one burst line
   input wire logic [17:0] wr_addr, // line address
   input wire logic [143:0] wr_data, // four slots of 36 bits
   input wire logic [15:0] wr_lane_en, // one enable per slot lane
   input wire logic [17:0] rd_addr, // line address to read
   output logic [143:0] rd_data // registered read line
);
   genvar g;
   ////////////////////////////////////////////////////////////////////////////
   // one narrow memory per lane, so each lane write has its own driver
   for (g = 0; g < bfs_pkg::LINE_LANES; g++) begin : g_lane
      logic [8:0] lane_ram [0:262143];
      logic [8:0] lane_rd_ff;
      always_ff @(posedge clk) begin
         if (wr_en && wr_lane_en[g]) begin
            lane_ram[wr_addr] <= wr_data[g*bfs_pkg::LANE_W +: bfs_pkg::LANE_W];
         end
         lane_rd_ff <= lane_ram[rd_addr];
      end
      assign rd_data[g*bfs_pkg::LANE_W +: bfs_pkg::LANE_W] = lane_rd_ff;
   end
endmodule // bfs_line_mem

// File: bfs_burst_port.sv
`timescale 1ns/10ps
module bfs_burst_port (
   input wire logic clock, // system clock
   input wire logic srst, // synchronous reset, active high
   input wire logic link_clock, // true input clock; its fall is the complement edge
   input wire logic address_load_n, // load new address when low
   input wire logic read_write, // high reads, low writes
   input wire logic [17:0] array_address, // burst line address
   input wire logic burst_addr_bit0, // burst start, low bit
   input wire logic burst_addr_bit1, // burst start, high bit
   input wire logic [3:0] byte_lane_write_n, // per-lane write enable, low active
   input wire logic [35:0] dq_in, // data pins, input side
   output logic [35:0] dq_out, // data pins, output side
   output logic dq_oe_n, // data pin enable, low while driving
   output logic echo_clock, // echo clock, true
   output logic echo_clock_n, // echo clock, complement
   input wire logic [5:0] impedance_sense_pin, // comparator code from the sense pin
   output logic [5:0] impedance_code, // driver impedance setting
   output logic impedance_ready, // first calibration done
   output logic dll_locked // loop counted as locked
);
   ////////////////////////////////////////////////////////////////////////////
   // link domain declarations
   logic lrst_meta_ff, lrst_ff;
   logic [17:0] addr_ff, wa_addr_ff, last_addr_ff;
   logic [1:0] start_ff, wa_start_ff, rl_start_ff;
   logic [2:0] rd_sh_ff, wr_sh_ff;
   logic [35:0] pd0_ff, pd2_ff, nd1_ff, nd3_ff, q_rise_ff, q_fall_ff;
   logic [3:0] pm0_ff, pm2_ff, nm1_ff, nm3_ff;
   logic [143:0] last_line_ff, rl_line_ff, mem_rd, wr_line, m1_line, m2_line;
   logic [15:0] last_mask_ff, wr_mask;
   logic last_vld_ff, oe_r_ff, oe_f_ff, ph_r_ff, ph_f_ff, act_tgl_ff;
   logic [35:0] wbeat [4];
   logic [3:0] wbeat_m [4];
   logic [35:0] rd_beat [4];
   // sys domain declarations
   logic act_s1_ff, act_s2_ff, act_s3_ff;
   logic [3:0] idle_cnt_ff;
   logic [10:0] lock_cnt_ff, cal_cnt_ff, per_cnt_ff;
   logic [5:0] zq_s1_ff, zq_s2_ff, zq_code_ff;
   logic zq_rdy_ff, locked_ff;

   ////////////////////////////////////////////////////////////////////////////
   // reset reaches the link domain through two flops; link clock must run
   always_ff @(posedge link_clock) begin
      lrst_meta_ff <= srst;
      lrst_ff <= lrst_meta_ff;
   end

   // command decode at the true edge
   wire cmd_load = ~address_load_n;
   wire cmd_rd = cmd_load & read_write;
   wire cmd_wr = cmd_load & ~read_write;
   wire [1:0] pin_start = {burst_addr_bit1, burst_addr_bit0};
   wire mem_we = wr_sh_ff[2];
   wire hit_last = last_vld_ff & (last_addr_ff == addr_ff);
   wire hit_cur = wr_sh_ff[2] & (wa_addr_ff == addr_ff);
   wire ddr_sel = ph_r_ff ^ ph_f_ff;

   ////////////////////////////////////////////////////////////////////////////
   // address and command pipelines on the true edge
   always_ff @(posedge link_clock) begin
      if (lrst_ff) begin
         rd_sh_ff <= bfs_pkg::SHIFT_ZERO;
         wr_sh_ff <= bfs_pkg::SHIFT_ZERO;
         addr_ff <= '0;
         start_ff <= 2'h0;
      end else begin
         rd_sh_ff <= {rd_sh_ff[1:0], cmd_rd};
         wr_sh_ff <= {wr_sh_ff[1:0], cmd_wr};
         if (cmd_load) begin
            addr_ff <= array_address;
            start_ff <= pin_start;
         end
      end
   end

   // write beats 0 and 2 on the true edge; address moves to the write side
   // at beat 0 so a following command may reload addr_ff
   always_ff @(posedge link_clock) begin
      if (wr_sh_ff[0]) begin
         wa_addr_ff <= addr_ff;
         wa_start_ff <= start_ff;
         pd0_ff <= dq_in;
         pm0_ff <= ~byte_lane_write_n;
      end
      if (wr_sh_ff[1]) begin
         pd2_ff <= dq_in;
         pm2_ff <= ~byte_lane_write_n;
      end
   end

   // write beats 1 and 3 on the complement edge
   always_ff @(negedge link_clock) begin
      if (wr_sh_ff[1]) begin
         nd1_ff <= dq_in;
         nm1_ff <= ~byte_lane_write_n;
      end
      if (wr_sh_ff[2]) begin
         nd3_ff <= dq_in;
         nm3_ff <= ~byte_lane_write_n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // beats rotate into line slots by the two-bit wrapping start offset
   assign wbeat[0] = pd0_ff;
   assign wbeat[1] = nd1_ff;
   assign wbeat[2] = pd2_ff;
   assign wbeat[3] = nd3_ff;
   assign wbeat_m[0] = pm0_ff;
   assign wbeat_m[1] = nm1_ff;
   assign wbeat_m[2] = pm2_ff;
   assign wbeat_m[3] = nm3_ff;
   genvar j;
   for (j = 0; j < bfs_pkg::BEATS; j++) begin : g_slot
      wire [1:0] wsel = 2'(j) - wa_start_ff;
      wire [1:0] rslot = 2'(j) + rl_start_ff;
      assign wr_line[j*bfs_pkg::DATA_W +: bfs_pkg::DATA_W] = wbeat[wsel];
      assign wr_mask[j*bfs_pkg::LANES +: bfs_pkg::LANES] = wbeat_m[wsel];
      assign rd_beat[j] = rl_line_ff[bfs_pkg::DATA_W*rslot +: bfs_pkg::DATA_W];
   end

   // read merge: array, then last committed write, then the one committing now
   genvar g;
   for (g = 0; g < bfs_pkg::LINE_LANES; g++) begin : g_merge
      localparam int LO = g*bfs_pkg::LANE_W;
      assign m1_line[LO +: bfs_pkg::LANE_W] = (hit_last & last_mask_ff[g]) ?
         last_line_ff[LO +: bfs_pkg::LANE_W] : mem_rd[LO +: bfs_pkg::LANE_W];
      assign m2_line[LO +: bfs_pkg::LANE_W] = (hit_cur & wr_mask[g]) ?
         wr_line[LO +: bfs_pkg::LANE_W] : m1_line[LO +: bfs_pkg::LANE_W];
   end

   // the array sees a whole line per commit, lanes gated by their masks
   bfs_line_mem u_mem (
      .clk(link_clock),
      .wr_en(mem_we),
      .wr_addr(wa_addr_ff),
      .wr_data(wr_line),
      .wr_lane_en(wr_mask),
      .rd_addr(array_address),
      .rd_data(mem_rd)
   );

   // latest write kept for coherency after it reaches the array
   always_ff @(posedge link_clock) begin
      if (lrst_ff) begin
         last_vld_ff <= 1'b0;
      end else if (mem_we) begin
         last_vld_ff <= 1'b1;
         last_addr_ff <= wa_addr_ff;
         last_line_ff <= wr_line;
         last_mask_ff <= wr_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read line latched one cycle after the command, beats 1 and 3 on true edge
   always_ff @(posedge link_clock) begin
      if (lrst_ff) begin
         oe_r_ff <= 1'b0;
         q_rise_ff <= '0;
         ph_r_ff <= 1'b0;
         act_tgl_ff <= 1'b0;
      end else begin
         ph_r_ff <= ~ph_r_ff;
         act_tgl_ff <= ~act_tgl_ff;
         oe_r_ff <= rd_sh_ff[1] | rd_sh_ff[2];
         if (rd_sh_ff[1]) begin
            q_rise_ff <= rd_beat[1];
         end else if (rd_sh_ff[2]) begin
            q_rise_ff <= rd_beat[3];
         end
      end
   end

   always_ff @(posedge link_clock) begin
      if (rd_sh_ff[0]) begin
         rl_line_ff <= m2_line;
         rl_start_ff <= start_ff;
      end
   end

   // beats 0 and 2 on the complement edge; the input pair times the output,
   // so no separate output clock is needed
   always_ff @(negedge link_clock) begin
      if (lrst_ff) begin
         oe_f_ff <= 1'b0;
         q_fall_ff <= '0;
         ph_f_ff <= 1'b0;
      end else begin
         // copy, not toggle: reset leaves this flop half a cycle before ph_r_ff
         ph_f_ff <= ph_r_ff;
         oe_f_ff <= rd_sh_ff[1] | rd_sh_ff[2];
         if (rd_sh_ff[1]) begin
            q_fall_ff <= rd_beat[0];
         end else if (rd_sh_ff[2]) begin
            q_fall_ff <= rd_beat[2];
         end
      end
   end

   // pins pick the flop of the last edge; a stopped clock freezes all of them
   assign dq_out = ddr_sel ? q_rise_ff : q_fall_ff;
   assign dq_oe_n = ddr_sel ? ~oe_r_ff : ~oe_f_ff;
   assign echo_clock = ddr_sel;
   assign echo_clock_n = ~ddr_sel;

   ////////////////////////////////////////////////////////////////////////////
   // link activity toggle crosses in two flops; third flop finds its edge
   always_ff @(posedge clock) begin
      act_s1_ff <= act_tgl_ff;
      act_s2_ff <= act_s1_ff;
      act_s3_ff <= act_s2_ff;
      zq_s1_ff <= impedance_sense_pin; // quasi-static comparator code
      zq_s2_ff <= zq_s1_ff;
   end

   wire link_tick = act_s2_ff ^ act_s3_ff;
   wire link_stopped = (idle_cnt_ff == bfs_pkg::STOP_DETECT);
   wire zq_step = ~zq_rdy_ff | (per_cnt_ff == bfs_pkg::ZQ_PERIOD);
   wire [5:0] zq_next = (zq_code_ff < zq_s2_ff) ? zq_code_ff + 6'h01 :
                        (zq_code_ff > zq_s2_ff) ? zq_code_ff - 6'h01 : zq_code_ff;

   // a quiet link restarts the lock count from zero
   always_ff @(posedge clock) begin
      if (srst) begin
         idle_cnt_ff <= 4'h0;
         lock_cnt_ff <= bfs_pkg::CNT_ZERO;
         locked_ff <= 1'b0;
      end else begin
         idle_cnt_ff <= link_tick ? 4'h0 : (link_stopped ? idle_cnt_ff : idle_cnt_ff + 4'h1);
         if (link_stopped) begin
            lock_cnt_ff <= bfs_pkg::CNT_ZERO;
            locked_ff <= 1'b0;
         end else if (link_tick && !locked_ff) begin
            lock_cnt_ff <= lock_cnt_ff + 11'h001;
            locked_ff <= (lock_cnt_ff == bfs_pkg::LOCK_CYCLES - 11'h001);
         end
      end
   end

   // impedance walks one step a cycle until settled, then once per period
   always_ff @(posedge clock) begin
      if (srst) begin
         zq_code_ff <= bfs_pkg::ZQ_MID;
         cal_cnt_ff <= bfs_pkg::CNT_ZERO;
         per_cnt_ff <= bfs_pkg::CNT_ZERO;
         zq_rdy_ff <= 1'b0;
      end else begin
         if (zq_step) begin
            zq_code_ff <= zq_next;
         end
         if (!zq_rdy_ff) begin
            cal_cnt_ff <= cal_cnt_ff + 11'h001;
            zq_rdy_ff <= (cal_cnt_ff == bfs_pkg::CAL_CYCLES - 11'h001);
         end
         per_cnt_ff <= (zq_step | ~zq_rdy_ff) ? bfs_pkg::CNT_ZERO : per_cnt_ff + 11'h001;
      end
   end

   assign impedance_code = zq_code_ff;
   assign impedance_ready = zq_rdy_ff;
   assign dll_locked = locked_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence rd_issue;
      cmd_rd ##1 1'b1;
   endsequence
   sequence wr_issue;
      cmd_wr ##1 1'b1;
   endsequence

   AST_READ_DRIVE: assert property (@(posedge link_clock) disable iff (lrst_ff)
      cmd_rd |-> ##3 oe_r_ff ##1 oe_r_ff)
      else $error("read burst not driven at its beats");
   AST_IDLE_NO_CUT: assert property (@(posedge link_clock) disable iff (lrst_ff)
      rd_issue ##0 address_load_n |-> ##2 oe_r_ff)
      else $error("idle cycle cut a read short");
   AST_READ_ORDER: assert property (@(posedge link_clock) disable iff (lrst_ff)
      rd_issue |-> ##2 q_rise_ff == $past(rd_beat[1]))
      else $error("second read beat out of order");
   AST_ADDR_HOLD: assert property (@(posedge link_clock) disable iff (lrst_ff)
      address_load_n |=> addr_ff == $past(addr_ff))
      else $error("address changed without load");
   AST_NO_WRITE_ON_READ: assert property (@(posedge link_clock) disable iff (lrst_ff)
      cmd_rd |-> ##1 !wr_sh_ff[0] ##2 !mem_we)
      else $error("read command started a write");
   AST_COMMIT_THIRD: assert property (@(posedge link_clock) disable iff (lrst_ff)
      wr_issue |-> ##2 (mem_we && wa_addr_ff == $past(addr_ff)))
      else $error("write not committed in third cycle");
   AST_LANE_MASK: assert property (@(posedge link_clock) disable iff (lrst_ff)
      wr_issue |=> pm0_ff == ~$past(byte_lane_write_n))
      else $error("first beat lane mask wrong");
   AST_ECHO_LOW_AT_TRUE: assert property (@(posedge link_clock) disable iff (lrst_ff)
      $past(!lrst_ff) |-> !echo_clock)
      else $error("echo clock out of step with data");
   AST_LOCK_DROPS: assert property (@(posedge clock) disable iff (srst)
      link_stopped |=> !locked_ff && lock_cnt_ff == bfs_pkg::CNT_ZERO)
      else $error("lock kept across a clock stop");
   AST_ZQ_NOT_EARLY: assert property (@(posedge clock)
      srst ##1 !srst |-> !zq_rdy_ff[*8])
      else $error("impedance ready too early");
endmodule // bfs_burst_port

// File: bfs_ctrl_model.sv
`timescale 1ns/10ps
module bfs_ctrl_model (
   input wire logic run, // link clock enable
   output logic link_clock, // true input clock
   output logic address_load_n, // command strobe, low active
   output logic read_write, // high reads, low writes
   output logic [17:0] array_address, // burst line address
   output logic burst_addr_bit0, // start slot, low bit
   output logic burst_addr_bit1, // start slot, high bit
   output logic [3:0] byte_lane_write_n, // lane enables, low active
   output logic [35:0] dq_in, // write data
   input wire logic [35:0] dq_out, // read data
   input wire logic dq_oe_n, // read drive enable, low active
   input wire logic echo_clock // echo clock, true
);
   // idle bus at time zero
   initial begin
      link_clock = 1'b0;
      address_load_n = 1'b1;
      read_write = 1'b1;
      array_address = 18'h00000;
      {burst_addr_bit1, burst_addr_bit0} = 2'h0;
      byte_lane_write_n = 4'hf;
      dq_in = 36'h000000000;
   end
   ////////////////////////////////////////
   // parks low when stopped so no runt pulse; the fall is the complement edge
   always #3 if (run || link_clock) link_clock = ~link_clock;
   ////////////////////////////////////////
   // one burst of four; callers keep commands two link cycles apart
   task automatic burst(input logic wr, input logic [17:0] a, input logic [1:0] s,
         input logic [143:0] d, input logic [15:0] m, output logic [143:0] q,
         output logic [8:0] f);
      @(posedge link_clock);
      #1;
      address_load_n = 1'b0;
      read_write = ~wr;
      array_address = a;
      {burst_addr_bit1, burst_addr_bit0} = s;
      @(posedge link_clock);
      #1;
      // scramble address and direction once taken, they must be ignored
      address_load_n = 1'b1;
      array_address = ~a;
      read_write = wr;
      if (!wr) @(posedge link_clock);
      for (int i = 0; i < 4; i++) begin
         if (i[0]) @(posedge link_clock);
         else @(negedge link_clock);
         #1;
         if (wr) begin
            dq_in = d[36*i+:36];
            byte_lane_write_n = m[4*i+:4];
         end else begin
            q[36*i+:36] = dq_out;
            f[2*i+:2] = {echo_clock, dq_oe_n};
            // released bus toggles with lanes open: a read must store none of it
            if (i < 2) begin
               dq_in = ~dq_in;
               byte_lane_write_n = 4'h0;
            end
         end
      end
      if (!wr) begin
         @(negedge link_clock);
         #1;
         f[8] = dq_oe_n;
      end
   endtask
endmodule // bfs_ctrl_model

// File: testbench.sv
`timescale 1ns/10ps
module testbench;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic run = 1'b1;
   logic link_clock, address_load_n, read_write, burst_addr_bit0, burst_addr_bit1;
   logic dq_oe_n, echo_clock, echo_clock_n, impedance_ready, dll_locked;
   logic [17:0] array_address;
   logic [3:0] byte_lane_write_n;
   logic [35:0] dq_in, dq_out, held;
   logic [5:0] impedance_sense_pin, impedance_code;
   logic [35:0] mem [int];
   logic [17:0] lines [4];
   int errors = 0;
   int compares = 0;
   int seed = 94321;
   int k;
   ////////////////////////////////////////
   // system clock, 5 ns
   always #2.5 clock = ~clock;
   bfs_burst_port u_bfs_burst_port (.clock(clock), .srst(srst), .link_clock(link_clock),
      .address_load_n(address_load_n), .read_write(read_write),
      .array_address(array_address), .burst_addr_bit0(burst_addr_bit0),
      .burst_addr_bit1(burst_addr_bit1), .byte_lane_write_n(byte_lane_write_n),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .echo_clock(echo_clock),
      .echo_clock_n(echo_clock_n), .impedance_sense_pin(impedance_sense_pin),
      .impedance_code(impedance_code), .impedance_ready(impedance_ready),
      .dll_locked(dll_locked));
   bfs_ctrl_model u_bfs_ctrl_model (.run(run), .link_clock(link_clock),
      .address_load_n(address_load_n), .read_write(read_write),
      .array_address(array_address), .burst_addr_bit0(burst_addr_bit0),
      .burst_addr_bit1(burst_addr_bit1), .byte_lane_write_n(byte_lane_write_n),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .echo_clock(echo_clock));
   ////////////////////////////////////////
   // compare and count
   task automatic chk(input logic [143:0] seen, input logic [143:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // a bound used up counts as a mismatch and ends the run
   task automatic tmo(input int n, input int lim);
      if (n >= lim) begin
         errors++;
         results();
      end
   endtask
   // model updated at command time, so a read just behind a write sees it
   // nx: a read follows two cycles later, so the drivers stay on after beat 3
   task automatic op(input logic wr, input int li, input logic [15:0] m, input logic nx);
      logic [159:0] r;
      logic [143:0] e, q;
      logic [8:0] f;
      logic [1:0] s;
      int key;
      r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      s = r[145:144];
      for (int i = 0; i < 4; i++) begin
         key = lines[li] * 4 + ((s + i) % 4);
         for (int b = 0; b < 4; b++) begin
            if (wr && !m[4*i+b]) mem[key][9*b+:9] = r[36*i+9*b+:9];
         end
         e[36*i+:36] = mem[key];
      end
      u_bfs_ctrl_model.burst(wr, lines[li], s, r[143:0], m, q, f);
      if (!wr) begin
         chk(q, e);
         chk(f, {~nx, 8'h88});
      end
   endtask
   ////////////////////////////////////////
   // main sequence
   initial begin
      impedance_sense_pin = 6'($random(seed));
      for (int i = 0; i < 4; i++)
         lines[i] = 18'($random(seed));
      // two reset flops in the link domain need more than two link cycles
      repeat (10) @(posedge clock);
      #1;
      chk({dq_oe_n, echo_clock, echo_clock_n, impedance_code, impedance_ready, dll_locked},
         11'h580);
      srst = 1'b0;
      $display("test reset done");
      k = 0;
      while (impedance_ready !== 1'b1 && k < 1100) begin
         @(posedge clock);
         #1;
         k++;
      end
      tmo(k, 1100);
      chk(k >= 1023 && k <= 1026, 1'b1);
      chk(impedance_code, impedance_sense_pin);
      $display("test impedance done");
      for (int i = 0; i < 4; i++)
         op(1'b1, i, 16'h0000, 1'b0);
      // pairs two cycles apart: every order of read and write, often one line
      for (int n = 0; n < 32; n++) begin
         k = $random(seed) & 3;
         fork
            op(n[0], k, 16'($random(seed)), ~n[1]);
            begin
               repeat (2) @(posedge link_clock);
               op(n[1], n[2] ? k : (k + 1) % 4, 16'($random(seed)), 1'b0);
            end
         join
      end
      $display("test bursts done");
      @(posedge clock);
      #1;
      impedance_sense_pin = impedance_sense_pin ^ 6'h01;
      repeat (600) @(posedge clock);
      #1;
      chk(impedance_code, impedance_sense_pin);
      k = 0;
      while (dll_locked !== 1'b1 && k < 2000) begin
         @(posedge clock);
         #1;
         k++;
      end
      tmo(k, 2000);
      // all bursts are done before the link clock stops; snapshot after it parks low
      run = 1'b0;
      repeat (2) @(posedge clock);
      #1;
      held = dq_out;
      repeat (40) @(posedge clock);
      #1;
      chk({dll_locked, dq_oe_n, echo_clock_n, dq_out}, {3'b011, held});
      $display("test stop done");
      run = 1'b1;
      k = 0;
      while (dll_locked !== 1'b1 && k < 1100) begin
         @(posedge link_clock);
         #1;
         k++;
      end
      tmo(k, 1100);
      chk(k >= 1024 && k <= 1032, 1'b1);
      op(1'b0, 0, 16'h0000, 1'b0);
      $display("test restart done");
      results();
   end
endmodule // testbench
